// ---- usc_pkg.sv ----
// constants and types for the usart clock and frame core
//
// Contract
// - baud down-counter runs on sys_clk, reloads divisor at zero or low-byte write
// - one baud tick each time the down-counter reaches zero
// - transmit bit clock is ticks divided by 16, 8 or 2 by mode
// - receiver consumes ticks directly with 16 or 8 states per bit; synchronous takes one bit per sample edge
// - bit rate is sys_clk over 16, 8 or 2 times divisor plus one
// - divisor is 12 bits, from high and low divisor parts
// - double speed drops divisor and receive samples from 16 to 8
// - sync select 1 is synchronous; pin direction picks master or slave
// - transfer clock pin neither driven nor sampled in asynchronous modes
// - slave clock is synchronised then edge detected, two cycles latency
// - synchronous receive samples on the edge opposite the transmit change
// - polarity 0 changes on rising, samples falling; 1 the reverse
// - frames are start, 5 to 9 data, optional parity, one or two stops
// - start bit, data lsb first, parity, then stop bits
// - after stop bits send next frame at once or idle high
// - single transmit write buffer ahead of shift register, no gap
// - receive data backed by two-entry fifo, each read pops one
// - frame error, overrun and ninth bit stored per fifo entry
// - with fifo full a finished character waits in shifter until next start
// - receiver accepts same formats, flags frame, overrun and parity errors
// - only the first stop bit is checked for frame error
// - parity is xor of data bits, inverted for odd
package usc_pkg;
  localparam int DIV_W        = 12;
  localparam int DATA_W       = 9;
  localparam logic [3:0] OSR_NORMAL = 4'hF;
  localparam logic [3:0] OSR_DOUBLE = 4'h7;
  localparam logic [3:0] OSR_SYNC   = 4'h1;
  localparam logic [3:0] OSR_MID_N  = 4'h8;
  localparam logic [3:0] OSR_MID_D  = 4'h4;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] PAR_ODD    = 2'h3;
  localparam logic [2:0] CS_NINE    = 3'h7;
  localparam logic [3:0] DBITS_BASE = 4'h5;

  typedef enum logic [2:0]
  {
    USC_IDLE   = 3'b000,
    USC_START  = 3'b001,
    USC_DATA   = 3'b010,
    USC_PARITY = 3'b011,
    USC_STOP1  = 3'b100,
    USC_STOP2  = 3'b101
  } usc_state_e;

  // data bits count from character size code (5..9)
  function automatic logic [3:0] usc_nbits(input logic [2:0] cs);
    if (cs == CS_NINE)
      usc_nbits = 4'h9;
    else
      usc_nbits = DBITS_BASE + {2'h0, cs[1:0]};
  endfunction
endpackage

// ---- usc_clkgen.sv ----
// baud generator and synchronous transfer clock handling
`timescale 1ns/1ps
`default_nettype none
module usc_clkgen
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [usc_pkg::DIV_W-1:0]  baud_divisor,
  input  wire logic                       baud_divisor_low_wr,
  input  wire logic                       sync_mode,
  input  wire logic                       sync_master,
  input  wire logic                       sync_clock_polarity,
  input  wire logic                       xck_in,
  output logic                            baud_tick,
  output logic                            xck_out,
  output logic                            xck_oe,
  output logic                            change_pulse,
  output logic                            sample_pulse
);
  // ===========================================================
  // baud down-counter
  logic [usc_pkg::DIV_W-1:0] count;
  logic                      xck_meta;
  logic                      xck_sync;
  logic                      xck_prev;
  logic                      master_clk;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (baud_divisor_low_wr || count == '0)
      count <= baud_divisor;
    else
      count <= count - 1'b1;
  end

  assign baud_tick = rst_n && (count == '0);

  // ===========================================================
  // master: divide ticks by 2 into the pin clock
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !sync_mode || !sync_master)
      master_clk <= 1'b0;
    else if (baud_tick)
      master_clk <= ~master_clk;
  end

  assign xck_out = master_clk ^ sync_clock_polarity;
  assign xck_oe  = sync_mode && sync_master;

  // ===========================================================
  // slave: synchroniser and edge detector
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      xck_meta <= 1'b0;
      xck_sync <= 1'b0;
      xck_prev <= 1'b0;
    end
    else
    begin
      xck_meta <= xck_in && sync_mode && !sync_master;
      xck_sync <= xck_meta;
      xck_prev <= xck_sync;
    end
  end

  logic rise;
  logic fall;
  always_comb
  begin
    if (!sync_mode)
    begin
      rise = 1'b0;
      fall = 1'b0;
    end
    else if (sync_master)
    begin
      rise = baud_tick && !master_clk;
      fall = baud_tick && master_clk;
    end
    else
    begin
      rise = xck_sync && !xck_prev;
      fall = !xck_sync && xck_prev;
    end
  end

  // internal rise means pin edge of the "change" kind after polarity
  assign change_pulse = rise;
  assign sample_pulse = fall;

  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    baud_divisor_low_wr |=> count == $past(baud_divisor))
    else $error("divisor not reloaded on low write");
  AST_PIN_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sync_mode |-> !xck_oe && !change_pulse && !sample_pulse)
    else $error("pin active in asynchronous mode");
endmodule
`default_nettype wire

// ---- usc_core.sv ----
// usart clock and frame core top
`timescale 1ns/1ps
`default_nettype none
module usc_core
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [3:0]                 baud_divisor_high,
  input  wire logic [7:0]                 baud_divisor_low,
  input  wire logic                       baud_divisor_low_wr,
  input  wire logic                       sync_select,
  input  wire logic                       xfer_clock_pin_direction,
  input  wire logic                       double_speed,
  input  wire logic                       sync_clock_polarity,
  input  wire logic [2:0]                 char_size,
  input  wire logic [1:0]                 parity_mode,
  input  wire logic                       two_stop_bits,
  input  wire logic                       tx_enable,
  input  wire logic                       rx_enable,
  input  wire logic [8:0]                 tx_data,
  input  wire logic                       tx_write,
  output logic                            tx_buffer_empty,
  output logic                            tx_complete,
  output logic                            txd,
  input  wire logic                       rxd,
  input  wire logic                       transfer_clock_pin_in,
  output logic                            transfer_clock_pin_out,
  output logic                            transfer_clock_pin_oe,
  input  wire logic                       serial_data_register_read,
  output logic [8:0]                      serial_data_register,
  output logic                            rx_ninth_bit,
  output logic                            frame_error_flag,
  output logic                            overrun_flag,
  output logic                            parity_error_flag,
  output logic                            rx_complete
);
  // ===========================================================
  // clock generation
  logic baud_tick;
  logic change_pulse;
  logic sample_pulse;
  logic pin_level;

  usc_clkgen u_clkgen
  (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .baud_divisor        ({baud_divisor_high, baud_divisor_low}),
    .baud_divisor_low_wr (baud_divisor_low_wr),
    .sync_mode           (sync_select),
    .sync_master         (xfer_clock_pin_direction),
    .sync_clock_polarity (sync_clock_polarity),
    .xck_in              (pin_level),
    .baud_tick           (baud_tick),
    .xck_out             (transfer_clock_pin_out),
    .xck_oe              (transfer_clock_pin_oe),
    .change_pulse        (change_pulse),
    .sample_pulse        (sample_pulse)
  );
  // polarity folded in so the internal edges are change/sample
  assign pin_level = transfer_clock_pin_in ^ sync_clock_polarity;

  logic [3:0] nbits;
  logic [3:0] osr_top;
  assign nbits = usc_pkg::usc_nbits(char_size);
  always_comb
  begin
    if (sync_select)
      osr_top = usc_pkg::OSR_SYNC;
    else if (double_speed)
      osr_top = usc_pkg::OSR_DOUBLE;
    else
      osr_top = usc_pkg::OSR_NORMAL;
  end

  // ===========================================================
  // transmitter
  usc_pkg::usc_state_e tx_state;
  logic [8:0] tx_buf;
  logic       tx_full;
  logic [8:0] tx_shift;
  logic [3:0] tx_cnt;
  logic       tx_par;
  logic       tx_bit_tick;
  logic       tx_load;
  logic       tx_frame_end;

  logic [3:0] tx_pre;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tx_pre <= '0;
    else if (!sync_select && baud_tick)
      tx_pre <= (tx_pre >= osr_top) ? 4'h0 : tx_pre + 4'h1;
  end

  always_comb
  begin
    if (sync_select)
      tx_bit_tick = change_pulse;
    else
      tx_bit_tick = baud_tick && (tx_pre >= osr_top);
  end

  assign tx_load = tx_full && tx_enable && tx_bit_tick &&
                   (tx_state == usc_pkg::USC_IDLE || tx_frame_end);
  assign tx_frame_end = tx_bit_tick &&
    ((tx_state == usc_pkg::USC_STOP1 && !two_stop_bits) ||
     tx_state == usc_pkg::USC_STOP2);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tx_full <= 1'b0;
    else if (tx_write && !tx_full)
      tx_full <= 1'b1;
    else if (tx_load)
      tx_full <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tx_buf <= '0;
    else if (tx_write && !tx_full)
      tx_buf <= tx_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tx_state <= usc_pkg::USC_IDLE;
      tx_shift <= '0;
      tx_cnt   <= '0;
      tx_par   <= 1'b0;
      txd      <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_state <= usc_pkg::USC_START;
      tx_shift <= tx_buf;
      tx_cnt   <= '0;
      tx_par   <= parity_mode[0];
      txd      <= 1'b0;
    end
    else if (tx_bit_tick)
    begin
      case (tx_state)
        usc_pkg::USC_START, usc_pkg::USC_DATA:
        begin
          if (tx_state == usc_pkg::USC_DATA && tx_cnt == nbits)
          begin
            if (parity_mode != usc_pkg::PAR_NONE)
            begin
              tx_state <= usc_pkg::USC_PARITY;
              txd      <= tx_par;
            end
            else
            begin
              tx_state <= usc_pkg::USC_STOP1;
              txd      <= 1'b1;
            end
          end
          else
          begin
            tx_state <= usc_pkg::USC_DATA;
            txd      <= tx_shift[0];
            tx_par   <= tx_par ^ tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_cnt   <= tx_cnt + 4'h1;
          end
        end
        usc_pkg::USC_PARITY:
        begin
          tx_state <= usc_pkg::USC_STOP1;
          txd      <= 1'b1;
        end
        usc_pkg::USC_STOP1:
        begin
          tx_state <= two_stop_bits ? usc_pkg::USC_STOP2
                                    : usc_pkg::USC_IDLE;
          txd      <= 1'b1;
        end
        default:
        begin
          tx_state <= usc_pkg::USC_IDLE;
          txd      <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tx_complete <= 1'b0;
    else if (tx_frame_end && !tx_load)
      tx_complete <= 1'b1;
    else if (tx_write)
      tx_complete <= 1'b0;
  end
  assign tx_buffer_empty = !tx_full;

  // ===========================================================
  // receiver
  usc_pkg::usc_state_e rx_state;
  logic [3:0] rx_os;
  logic [3:0] rx_cnt;
  logic [8:0] rx_shift;
  logic       rx_par;
  logic       rx_pe;
  logic       rx_fe;
  logic       rx_pending;
  logic       rx_pend_fe;
  logic       rx_pend_pe;
  logic       rx_ovr;
  logic       rx_mid;
  logic       rx_step;
  logic [3:0] rx_mid_pt;

  assign rx_mid_pt = double_speed ? usc_pkg::OSR_MID_D : usc_pkg::OSR_MID_N;
  // async: mid-bit on the oversample count; sync: sample edge
  assign rx_step = sync_select ? sample_pulse : baud_tick;
  assign rx_mid  = sync_select ? sample_pulse
                 : baud_tick && (rx_os == rx_mid_pt - 4'h1);

  logic [8:0] fifo_data [2];
  logic [1:0] fifo_fe;
  logic [1:0] fifo_pe;
  logic [1:0] fifo_ovr;
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] fifo_cnt;
  logic       fifo_push;
  logic       fifo_pop;
  logic       start_seen;
  logic       rx_done;

  assign fifo_pop  = serial_data_register_read && fifo_cnt != 2'h0;
  assign start_seen = rx_state == usc_pkg::USC_IDLE && rx_enable &&
                      rx_step && !rxd;
  assign fifo_push = rx_pending && (fifo_cnt != 2'h2 || fifo_pop);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !rx_enable)
    begin
      rx_state <= usc_pkg::USC_IDLE;
      rx_os    <= '0;
      rx_cnt   <= '0;
      rx_shift <= '0;
      rx_par   <= 1'b0;
      rx_pe    <= 1'b0;
      rx_fe    <= 1'b0;
      rx_done  <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (start_seen)
      begin
        // synchronous start is taken on its own sample edge
        rx_state <= sync_select ? usc_pkg::USC_DATA
                                : usc_pkg::USC_START;
        rx_os    <= '0;
        rx_cnt   <= '0;
        rx_par   <= parity_mode[0];
        rx_pe    <= 1'b0;
      end
      else if (rx_state != usc_pkg::USC_IDLE && rx_step)
      begin
        rx_os <= (rx_os >= osr_top) ? 4'h0 : rx_os + 4'h1;
      end
      if (rx_state != usc_pkg::USC_IDLE && !start_seen && rx_mid)
      begin
        case (rx_state)
          usc_pkg::USC_START:
          begin
            if (rxd && !sync_select)
              rx_state <= usc_pkg::USC_IDLE;
            else
              rx_state <= usc_pkg::USC_DATA;
          end
          usc_pkg::USC_DATA:
          begin
            rx_shift <= {rxd, rx_shift[8:1]};
            rx_par   <= rx_par ^ rxd;
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_cnt + 4'h1 == nbits)
              rx_state <= (parity_mode != usc_pkg::PAR_NONE)
                          ? usc_pkg::USC_PARITY : usc_pkg::USC_STOP1;
          end
          usc_pkg::USC_PARITY:
          begin
            rx_pe    <= rx_par ^ rxd;
            rx_state <= usc_pkg::USC_STOP1;
          end
          default:
          begin
            rx_fe    <= !rxd;
            rx_done  <= 1'b1;
            rx_state <= usc_pkg::USC_IDLE;
          end
        endcase
      end
    end
  end

  // right-align short characters held in the shifter
  logic [8:0] rx_aligned;
  assign rx_aligned = rx_shift >> (4'h9 - nbits);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rx_pending <= 1'b0;
      rx_pend_fe <= 1'b0;
      rx_pend_pe <= 1'b0;
      rx_ovr     <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_pending <= 1'b1;
      rx_pend_fe <= rx_fe;
      rx_pend_pe <= rx_pe;
    end
    else if (fifo_push)
    begin
      rx_pending <= 1'b0;
      rx_ovr     <= 1'b0;
    end
    else if (rx_pending && start_seen)
    begin
      rx_pending <= 1'b0;
      rx_ovr     <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      fifo_cnt <= '0;
      fifo_fe  <= '0;
      fifo_pe  <= '0;
      fifo_ovr <= '0;
      fifo_data[0] <= '0;
      fifo_data[1] <= '0;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_data[wr_ptr] <= rx_aligned;
        fifo_fe[wr_ptr]   <= rx_pend_fe;
        fifo_pe[wr_ptr]   <= rx_pend_pe;
        fifo_ovr[wr_ptr]  <= rx_ovr;
        wr_ptr            <= ~wr_ptr;
      end
      if (fifo_pop)
        rd_ptr <= ~rd_ptr;
      fifo_cnt <= fifo_cnt + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      serial_data_register <= '0;
    else
      serial_data_register <= (fifo_cnt == 2'h0 ||
                              (fifo_pop && fifo_cnt == 2'h1))
                              ? (fifo_push ? rx_aligned : 9'h000)
                              : fifo_data[fifo_pop ? ~rd_ptr : rd_ptr];
  end

  always_comb
  begin
    rx_ninth_bit      = serial_data_register[8];
    frame_error_flag  = fifo_cnt != 2'h0 && fifo_fe[rd_ptr];
    parity_error_flag = fifo_cnt != 2'h0 && fifo_pe[rd_ptr];
    overrun_flag      = fifo_cnt != 2'h0 && fifo_ovr[rd_ptr];
    rx_complete       = fifo_cnt != 2'h0;
  end

  AST_FIFO_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifo_cnt <= 2'h2)
    else $error("receive fifo count above two");
  AST_POP_ONCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifo_pop && !fifo_push |=> fifo_cnt == $past(fifo_cnt) - 2'h1)
    else $error("read did not pop one entry");
  AST_HOLD3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_pending && fifo_cnt == 2'h2 && !fifo_pop && !start_seen
    |=> rx_pending)
    else $error("third level lost early");
  AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_state == usc_pkg::USC_IDLE |-> txd)
    else $error("idle line not high");
  sequence s_load;
    tx_load;
  endsequence
  AST_START_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_load |=> !txd && tx_state == usc_pkg::USC_START)
    else $error("start bit not low");
  AST_BUF_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_write && !tx_full |=> tx_full)
    else $error("write buffer not filled");
endmodule
`default_nettype wire

// ---- usc_remote.sv ----
// remote serial transceiver model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module usc_remote
(
  input  wire logic sys_clk,
  output logic      line
);
  initial line = 1'h1;

  // =====================================================
  // one frame; bad[0] parity, bad[1] stop one, bad[2] stop two
  task automatic send(input logic [8:0] d, input int nb,
                      input logic [1:0] par, input logic s2,
                      input int bitc, input logic [2:0] bad);
    int i;
    send_bit(1'h0, bitc);
    for (i = 0; i < nb; i++)
      send_bit(d[i], bitc);
    if (par[1])
      send_bit(^(d & (9'h1FF >> (9 - nb))) ^ par[0] ^ bad[0], bitc);
    send_bit(~bad[1], bitc);
    if (s2)
      send_bit(~bad[2], bitc);
    line = 1'h1;
  endtask

  task automatic send_bit(input logic v, input int bitc);
    line = v;
    repeat (bitc) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- usc_core_tb.sv ----
// self-checking testbench for the usart clock and frame core
`timescale 1ns/1ps
`default_nettype none
module usc_core_tb;
  logic       sys_clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       low_wr = 1'h0;
  logic       sync_sel = 1'h0;
  logic       dir = 1'h0;
  logic       dspeed = 1'h0;
  logic       pol = 1'h0;
  logic [2:0] cs = 3'h3;
  logic [1:0] par = 2'h0;
  logic       s2 = 1'h0;
  logic       rx_en = 1'h0;
  logic [8:0] tx_data = 9'h000;
  logic       tx_write = 1'h0;
  logic       rd = 1'h0;
  logic       tx_empty, txd, rxd, pin_out, pin_oe, rx_done, fe, pe, ovr;
  logic       tx_comp, ninth;
  logic       transfer_clock_pin = 1'h0;
  logic [8:0] rdata;
  int         err_total = 0;
  int         comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  usc_core u_usc_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .baud_divisor_high(4'h0), .baud_divisor_low(8'h01),
    .baud_divisor_low_wr(low_wr), .sync_select(sync_sel),
    .xfer_clock_pin_direction(dir), .double_speed(dspeed),
    .sync_clock_polarity(pol), .char_size(cs), .parity_mode(par),
    .two_stop_bits(s2), .tx_enable(1'h1), .rx_enable(rx_en),
    .tx_data(tx_data), .tx_write(tx_write), .tx_buffer_empty(tx_empty),
    .tx_complete(tx_comp), .txd(txd), .rxd(rxd), .transfer_clock_pin_in(transfer_clock_pin),
    .transfer_clock_pin_out(pin_out), .transfer_clock_pin_oe(pin_oe),
    .serial_data_register_read(rd), .serial_data_register(rdata),
    .rx_ninth_bit(ninth), .frame_error_flag(fe), .overrun_flag(ovr),
    .parity_error_flag(pe), .rx_complete(rx_done));

  usc_remote u_usc_remote (.sys_clk(sys_clk), .line(rxd));

  // =====================================================
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (s !== v && n < lim)
    begin
      step(1);
      n++;
    end
    if (s !== v)
    begin
      err_total++;
      $display("wrong value at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  task automatic put(input logic [8:0] d);
    int n;
    wait_for(tx_empty, 1'h1, 2000, n);
    tx_data = d;
    tx_write = 1'h1;
    step(1);
    tx_write = 1'h0;
  endtask

  // sample each bit in its middle and compare with the frame
  task automatic get(input logic [8:0] d, input int nb, input int bitc,
                     input int lim);
    int i;
    wait_for(txd, 1'h0, lim, i);
    step(bitc / 2);
    check(txd, 1'h0);
    for (i = 0; i < nb; i++)
    begin
      step(bitc);
      check(txd, d[i]);
    end
    if (par[1])
    begin
      step(bitc);
      check(txd, ^(d & (9'h1FF >> (9 - nb))) ^ par[0]);
    end
    step(bitc);
    check(txd, 1'h1);
    if (s2)
    begin
      step(bitc);
      check(txd, 1'h1);
    end
  endtask

  task automatic pop(input logic [8:0] d, input logic ef, input logic ep,
                     input logic eo);
    int n;
    wait_for(rx_done, 1'h1, 500, n);
    check(rdata, d);
    check(ninth, d[8]);
    check(fe, ef);
    check(pe, ep);
    check(ovr, eo);
    rd = 1'h1;
    step(1);
    rd = 1'h0;
    step(2);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =====================================================
  // main sequence
  logic [2:0] cs_t [3] = '{3'h0, 3'h3, 3'h7};
  logic [1:0] par_t [3] = '{2'h0, 2'h2, 2'h3};
  int         nb_t [3] = '{5, 8, 9};
  int         k, n0, n1;
  logic [8:0] ex;

  initial
  begin
    step(5);
    rst_n = 1'h1;
    check(txd, 1'h1);
    check(rx_done, 1'h0);
    check(pin_oe, 1'h0);
    low_wr = 1'h1;
    step(1);
    low_wr = 1'h0;
    $display("test reset done");

    // divisor 1 gives 32 cycles a bit, two frames back to back
    for (k = 0; k < 3; k++)
    begin
      cs = cs_t[k];
      par = par_t[k];
      s2 = k[0];
      step(1);
      put(9'h1A5);
      put(9'h05A);
      get(9'h1A5, nb_t[k], 32, 200);
      get(9'h05A, nb_t[k], 32, 19);
    end
    $display("test transmit formats done");

    dspeed = 1'h1;
    put(9'h0C3);
    get(9'h0C3, 9, 16, 200);
    dspeed = 1'h0;
    $display("test double speed done");

    cs = 3'h3;
    par = 2'h2;
    s2 = 1'h1;
    rx_en = 1'h1;
    step(40);
    u_usc_remote.send(9'h03C, 8, 2'h2, 1'h1, 32, 3'h0);
    u_usc_remote.send(9'h0C3, 8, 2'h2, 1'h1, 32, 3'h1);
    pop(9'h03C, 1'h0, 1'h0, 1'h0);
    pop(9'h0C3, 1'h0, 1'h1, 1'h0);
    u_usc_remote.send(9'h081, 8, 2'h2, 1'h1, 32, 3'h2);
    u_usc_remote.send(9'h07E, 8, 2'h2, 1'h1, 32, 3'h4);
    pop(9'h081, 1'h1, 1'h0, 1'h0);
    pop(9'h07E, 1'h0, 1'h0, 1'h0);
    // the low second stop bit is taken as a new start over idle line
    pop(9'h0FF, 1'h0, 1'h1, 1'h0);
    check(tx_comp, 1'h1);
    $display("test receive done");

    // third level held in the shifter, then lost to a fourth start
    for (k = 0; k < 3; k++)
      u_usc_remote.send(9'h0A1 + 9'(k), 8, 2'h2, 1'h1, 32, 3'h0);
    for (k = 0; k < 3; k++)
      pop(9'h0A1 + 9'(k), 1'h0, 1'h0, 1'h0);
    for (k = 0; k < 4; k++)
      u_usc_remote.send(9'h011 * 9'(k + 1), 8, 2'h2, 1'h1, 32, 3'h0);
    pop(9'h011, 1'h0, 1'h0, 1'h0);
    pop(9'h022, 1'h0, 1'h0, 1'h0);
    pop(9'h044, 1'h0, 1'h0, 1'h1);
    $display("test receive buffer done");

    // double speed stays cleared in synchronous mode
    dspeed = 1'h0;
    sync_sel = 1'h1;
    dir = 1'h1;
    step(2);
    check(pin_oe, 1'h1);
    put(9'h055);
    check(tx_comp, 1'h0);
    wait_for(pin_out, 1'h1, 200, n0);
    wait_for(pin_out, 1'h0, 10, n0);
    wait_for(pin_out, 1'h1, 10, n0);
    wait_for(pin_out, 1'h0, 10, n1);
    check(9'(n0 + n1), 9'h004);
    step(80);
    sync_sel = 1'h0;
    dir = 1'h0;
    step(2);
    check(pin_oe, 1'h0);
    $display("test sync master done");

    // slave clock at a tenth of sys_clk, pin idles high
    par = 2'h0;
    pol = 1'h1;
    transfer_clock_pin = 1'h1;
    sync_sel = 1'h1;
    step(2);
    check(pin_oe, 1'h0);
    put(9'h1A5);
    for (k = 0; k < 10; k++)
    begin
      transfer_clock_pin = 1'h0;
      step(5);
      transfer_clock_pin = 1'h1;
      ex = (k == 0) ? 9'h000 : (9'h1A5 >> (k - 1)) & 9'h001;
      check(txd, ex);
      step(5);
    end
    $display("test sync slave done");
    print_verdict();
  end
endmodule
`default_nettype wire
